// ===== dv/epm_media_model.sv
/*
  Media devices on the far side of all multiplexed pins.
  Assumes pad outputs and active-low enables flattened into one vector.
*/
`timescale 1ns/10ps
module epm_media_model
(
  // clock
  input wire logic clk_i,
  // pad side of the device
  input wire logic [38:0] drv_i,
  input wire logic [38:0] oe_n_i,
  output logic [38:0] pad_o
);
  logic [38:0] pat_r = 39'h0;
  // released pins wander so a stale level never passes as data
  always @(posedge clk_i)
    pat_r <= {pat_r[37:0], ~pat_r[38]};
  assign pad_o = (drv_i & ~oe_n_i) | (pat_r & oe_n_i);
endmodule

// ===== dv/epm_pin_mux_props.sv
/*
  Port checker for the pin multiplexer.
  Assumes it is bound to epm_pin_mux and shadows route writes itself.
*/
`timescale 1ns/10ps
module epm_pin_mux_props
  import epm_pkg::*;
#(
  parameter int SER_PINS = 6,
  parameter int PAR_PINS = 21,
  parameter int GPIO_LINES = 32
)
(
  // clock, reset and cpu port
  input wire logic clk_i,
  input wire logic rst_i,
  input wire epm_pkg::epm_word_t addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire epm_pkg::epm_word_t wdata_i,
  input wire epm_pkg::epm_word_t rdata_o,
  // pins
  input wire logic [2*SER_PINS-1:0] card_out_i,
  input wire logic [GPIO_LINES-1:0] general_io_line_out_i,
  input wire logic [PAR_PINS-1:0] panel_out_i,
  input wire logic [5:0] ext_mem_addr_i,
  input wire logic [2*SER_PINS-1:0] ser_pad_o,
  input wire logic [PAR_PINS-1:0] par_pad_o,
  input wire logic [PAR_PINS-1:0] par_pad_oe_n_o,
  input wire logic [5:0] ext_mem_addr_pin_o
);
  epm_word_t sh_r;
  epm_word_t sh_nxt;
  // reserved bits dropped so reads compare whole words
  always_comb
  begin
    sh_nxt = sh_r;
    if (wr_i && addr_i == 16'h1C00)
      sh_nxt = wdata_i & 16'h7F3F;
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sh_r <= 16'h0000;
    else
      sh_r <= sh_nxt;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  read_back_a: assert property (rd_i && addr_i == 16'h1C00 |=> rdata_o == $past(sh_r))
    else $error("route read wrong");
  unmapped_read_a: assert property (rd_i && addr_i != 16'h1C00 |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  ser_card_a: assert property (sh_r[9:8] == 2'h0 |-> ser_pad_o[5:0] == card_out_i[5:0])
    else $error("serial 0 card route wrong");
  ser_gpio_a: assert property (sh_r[11:10] == 2'h2 |->
    ser_pad_o[11:6] == general_io_line_out_i[11:6])
    else $error("serial 1 gpio route wrong");
  par_panel_a: assert property (sh_r[14:12] == 3'h0 |-> par_pad_o == panel_out_i)
    else $error("panel route wrong");
  par_release_a: assert property (sh_r[14:12] == 3'h7 |-> &par_pad_oe_n_o)
    else $error("parallel code seven drives");
  addr_route_a: assert property (ext_mem_addr_pin_o == ((sh_r[5:0] &
    general_io_line_out_i[26:21]) | (~sh_r[5:0] & ext_mem_addr_i)))
    else $error("upper address route wrong");
  route_next_a: assert property (wr_i && addr_i == 16'h1C00 && wdata_i[14:12] == 3'h0
    |=> par_pad_o == panel_out_i)
    else $error("routing late after write");
endmodule
bind epm_pin_mux epm_pin_mux_props #(.SER_PINS(SER_PINS), .PAR_PINS(PAR_PINS),
  .GPIO_LINES(GPIO_LINES)) u_props (.clk_i, .rst_i, .addr_i, .wr_i, .rd_i, .wdata_i,
  .rdata_o, .card_out_i, .general_io_line_out_i, .panel_out_i, .ext_mem_addr_i,
  .ser_pad_o, .par_pad_o, .par_pad_oe_n_o, .ext_mem_addr_pin_o);

// ===== dv/external_bus_pin_mux_tb.sv
/*
  Self-checking bench for the pin multiplexer.
  Assumes the checker and media model are compiled before it.
*/
`timescale 1ns/10ps
module external_bus_pin_mux_tb;
  import epm_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, look = 1'b0;
  logic rd_d = 1'b0, lk_d = 1'b0;
  epm_word_t addr_i = '0, wdata_i = '0, rdata_o, rt = '0;
  logic [11:0] co = '0;
  logic [7:0] ao = '0, bo = '0;
  logic [6:0] so = '0;
  logic [3:0] uo = '0;
  logic [20:0] po = '0;
  logic [31:0] go = '0;
  logic [5:0] ea = '0;
  wire [38:0] pout, poe, pin;
  wire [97:6] vin;
  logic [93:0] exq[$];
  int err_total = 0, n_tests = 0, seed = 32'hd09a;
  always #50 clk_i = ~clk_i;
  epm_pin_mux u_dut
  (
    .clk_i, .rst_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
    // enables run inverted to the data, so a crossed enable and data path shows
    .card_out_i(co), .card_oe_i(~co), .card_in_o(vin[97:86]),
    .aud01_out_i(ao), .aud01_oe_i(~ao), .aud01_in_o(vin[85:78]),
    .aud23_out_i(bo), .aud23_oe_i(~bo), .aud23_in_o(vin[77:70]),
    .spi_out_i(so), .spi_oe_i(~so), .spi_in_o(vin[69:63]),
    .uart_out_i(uo), .uart_oe_i(~uo), .uart_in_o(vin[62:59]),
    .panel_out_i(po), .panel_oe_i(~po), .panel_in_o(vin[58:38]),
    .general_io_line_out_i(go), .general_io_line_oe_i(~go),
    .general_io_line_in_o(vin[37:6]),
    .ext_mem_addr_i(ea),
    .ser_pad_o(pout[38:27]), .ser_pad_oe_n_o(poe[38:27]), .ser_pad_i(pin[38:27]),
    .par_pad_o(pout[26:6]), .par_pad_oe_n_o(poe[26:6]), .par_pad_i(pin[26:6]),
    .ext_mem_addr_pin_o(pout[5:0]), .ext_mem_addr_pin_oe_n_o(poe[5:0]),
    .ext_mem_addr_pin_i(pin[5:0])
  );
  epm_media_model u_far (.clk_i, .drv_i(pout), .oe_n_i(poe), .pad_o(pin));
  // pad image of route r for a bundle {card, aud01, aud23, spi, uart, panel, gpio, addr}
  function automatic logic [38:0] mp(input epm_word_t r, input logic [97:0] v);
    logic [11:0] c, sr;
    logic [7:0] a, b, hi;
    logic [6:0] s;
    logic [3:0] u, ct, sp;
    logic [20:0] p;
    logic [31:0] g;
    logic [8:0] lo;
    {c, a, b, s, u, p, g} = v[97:6];
    for (int k = 0; k < 2; k++)
    begin
      case (r[8+2*k+:2])
        2'h0: sr[6*k+:6] = c[6*k+:6];
        2'h1: sr[6*k+:6] = {g[6*k+4+:2], a[4*k+:4]};
        2'h2: sr[6*k+:6] = g[6*k+:6];
        default: sr[6*k+:6] = 6'h00;
      endcase
    end
    lo = p[8:0];
    ct = p[20:17];
    sp = {s[2], s[1], s[3], s[0]};
    if (r[14:12] == 3'h1 || r[14:12] == 3'h6)
    begin
      lo = {g[17:12], s[2:0]};
      ct = s[6:3];
    end
    case (r[14:12])
      3'h0: hi = p[16:9];
      3'h1: hi = {u, b[3:0]};
      3'h2: hi = {g[31:27], g[20:18]};
      3'h3: hi = {b[7:4], sp};
      3'h4: hi = {u, b[3:0]};
      3'h5: hi = {u, sp};
      3'h6: hi = b;
      default: hi = 8'h00;
    endcase
    if (r[14:12] == 3'h7)
    begin
      lo = 9'h000;
      ct = 4'h0;
    end
    return {sr, ct, hi, lo, (r[5:0] & g[26:21]) | (~r[5:0] & v[5:0])};
  endfunction
  task automatic wr(input epm_word_t a, input epm_word_t d);
    @(negedge clk_i);
    {co, ao, bo, so, uo, po, go, ea} = '0;
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    if (a == 16'h1C00)
      rt = d & 16'h7F3F;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask
  task automatic rd(input epm_word_t a, input epm_word_t e);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'b1;
    exq.push_back({78'h0, e});
    @(negedge clk_i);
    rd_i = 1'b0;
  endtask
  task automatic pk();
    logic [127:0] r;
    logic [38:0] d, m;
    @(negedge clk_i);
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    {co, ao, bo, so, uo, po, go, ea} = r[97:0];
    d = mp(rt, r[97:0]);
    m = mp(rt, {98{1'b1}});
    // routed pins show the data on the enable too; released high; address duty low
    exq.push_back({rt, (d & ~{33'h0, ~rt[5:0]}) | ~m, d});
    look = 1'b1;
    @(negedge clk_i);
    look = 1'b0;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    rd_d <= rd_i;
    lk_d <= look;
  end
  // pads and enables, then pad levels looped back through the far side
  always @(negedge clk_i)
  begin : mon
    logic [93:0] e, a;
    logic [38:0] xi, gi;
    if (rd_d || lk_d)
    begin
      e = exq.pop_front();
      a = rd_d ? {78'h0, rdata_o} : {e[93:78], poe, pout};
      n_tests++;
      if (a !== e)
      begin
        err_total++;
        $display("mismatch at %0t exp %h got %h", $time, e, a);
      end
      if (lk_d)
      begin
        xi = pin & mp(e[93:78], {98{1'b1}});
        gi = mp(e[93:78], {vin, pin[5:0]});
        n_tests++;
        if (gi !== xi)
        begin
          err_total++;
          $display("mismatch at %0t exp %h got %h", $time, xi, gi);
        end
      end
    end
  end
  initial
  begin
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    rd(16'h1C00, 16'h0000);
    pk();
    $display("reset state done");
    // one write per pass; code seven is tried to see the pins let go
    for (int m = 0; m < 8; m++)
    begin
      wr(16'h1C00, {1'b1, m[2:0], ~m[1:0], m[1:0], 2'h3, 6'($random(seed))});
      rd(16'h1C00, rt);
      repeat (3) pk();
      $display("mode %0d done", m);
    end
    wr(16'h1C02, 16'h2A55);
    rd(16'h1C00, rt);
    rd(16'h1C01, 16'h0000);
    @(negedge clk_i);
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    rt = '0;
    rd(16'h1C00, 16'h0000);
    pk();
    $display("unmapped and reset done");
    @(negedge clk_i);
    final_report();
  end
  initial
  begin
    #1000000;
    err_total++;
    final_report();
  end
endmodule

// ===== logic/epm_map.svh
/*
  Register address, field positions and reset value of the pin route select register.
  Assumes the CPU reaches the register on its 16-bit I/O port by word address.
*/
`ifndef EPM_MAP_SVH
`define EPM_MAP_SVH

`define EPM_ROUTE_ADDR 16'h1C00
`define EPM_ROUTE_RESET 16'h0000
`define EPM_ROUTE_WMASK 16'h7F3F
`define EPM_UPPER_LSB 0
`define EPM_UPPER_MSB 5
`define EPM_SER0_LSB 8
`define EPM_SER0_MSB 9
`define EPM_SER1_LSB 10
`define EPM_SER1_MSB 11
`define EPM_PAR_LSB 12
`define EPM_PAR_MSB 14

`endif

// ===== logic/epm_pin_mux.sv
/*
  Pin multiplexer: routes peripheral signals onto two serial pin groups, the parallel
  pin group and the upper external-memory address pins under the route select register.
  Assumes peripheral outputs and pad inputs are synchronous to clk_i; peripheral
  enables are active high, pad enables active low.
*/
// Notes on behaviour
// - serial mode 00: card port on all six
// - serial mode 01: audio on 0-3, gpio 4-5
// - serial mode 10: six gpio lines per group
// - serial selects at bits 9:8, 11:10
// - parallel select at bits 14:12, seven modes
// - parallel mode 000: full 16-bit panel
// - mode 001: spi, gpio, audio2, uart
// - mode 010: 8-bit panel plus gpio
// - mode 011: 8-bit panel, spi, audio3
// - mode 100: 8-bit panel, audio2, uart
// - mode 101: 8-bit panel, spi, uart
// - mode 110: spi, gpio, audio2, audio3
// - new routing applies next clock cycle
// - upper address bit set means gpio
// - select bits 0-5 map address 15-20, gpio 21-26
`timescale 1ns/10ps
`include "epm_map.svh"

module epm_pin_mux
#(
  parameter int SER_PINS = 6,
  parameter int PAR_PINS = 21,
  parameter int GPIO_LINES = 32
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // cpu port
  input wire epm_pkg::epm_word_t addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire epm_pkg::epm_word_t wdata_i,
  output epm_pkg::epm_word_t rdata_o,
  // card ports, group 0 in [5:0], group 1 in [11:6]
  input wire logic [2*SER_PINS-1:0] card_out_i,
  input wire logic [2*SER_PINS-1:0] card_oe_i,
  output logic [2*SER_PINS-1:0] card_in_o,
  // audio 0 and 1: clk, fs, dx, rx per group
  input wire logic [7:0] aud01_out_i,
  input wire logic [7:0] aud01_oe_i,
  output logic [7:0] aud01_in_o,
  // audio 2 and 3: clk, fs, rx, dx each
  input wire logic [7:0] aud23_out_i,
  input wire logic [7:0] aud23_oe_i,
  output logic [7:0] aud23_in_o,
  // spi: clk, rx, tx, cs0..cs3
  input wire logic [6:0] spi_out_i,
  input wire logic [6:0] spi_oe_i,
  output logic [6:0] spi_in_o,
  // uart: rts, cts, rxd, txd
  input wire logic [3:0] uart_out_i,
  input wire logic [3:0] uart_oe_i,
  output logic [3:0] uart_in_o,
  // panel: pclk, data 0-15, bias, mclk, hsync, vsync
  input wire logic [PAR_PINS-1:0] panel_out_i,
  input wire logic [PAR_PINS-1:0] panel_oe_i,
  output logic [PAR_PINS-1:0] panel_in_o,
  // general io lines
  input wire logic [GPIO_LINES-1:0] general_io_line_out_i,
  input wire logic [GPIO_LINES-1:0] general_io_line_oe_i,
  output logic [GPIO_LINES-1:0] general_io_line_in_o,
  // memory controller upper address 20:15
  input wire logic [5:0] ext_mem_addr_i,
  // serial pads
  output logic [2*SER_PINS-1:0] ser_pad_o,
  output logic [2*SER_PINS-1:0] ser_pad_oe_n_o,
  input wire logic [2*SER_PINS-1:0] ser_pad_i,
  // parallel pads
  output logic [PAR_PINS-1:0] par_pad_o,
  output logic [PAR_PINS-1:0] par_pad_oe_n_o,
  input wire logic [PAR_PINS-1:0] par_pad_i,
  // upper address pads
  output logic [5:0] ext_mem_addr_pin_o,
  output logic [5:0] ext_mem_addr_pin_oe_n_o,
  input wire logic [5:0] ext_mem_addr_pin_i
);
  import epm_pkg::*;

  localparam int HI_GPIO [8] = '{18, 19, 20, 27, 28, 29, 30, 31};
  localparam int HI_SPI [4] = '{0, 3, 1, 2};

  epm_word_t route;
  epm_ser_mode_t ser_mode [2];
  epm_par_mode_t par_mode;
  logic [5:0] upper_addr_select;
  logic [2*SER_PINS-1:0] ser_oe;
  logic [PAR_PINS-1:0] par_oe;
  logic lo_alt;

  epm_route_reg u_route_reg
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata_o),
    .route_o(route)
  );

  // routing follows the register combinationally, so a write shows on the next cycle
  assign ser_mode[0] = epm_ser_mode_t'(route[`EPM_SER0_MSB:`EPM_SER0_LSB]);
  assign ser_mode[1] = epm_ser_mode_t'(route[`EPM_SER1_MSB:`EPM_SER1_LSB]);
  assign par_mode = epm_par_mode_t'(route[`EPM_PAR_MSB:`EPM_PAR_LSB]);
  assign upper_addr_select = route[`EPM_UPPER_MSB:`EPM_UPPER_LSB];
  assign lo_alt = (par_mode == EPM_PAR_GPIO_SPI_UART_AUD2) ||
                  (par_mode == EPM_PAR_GPIO_SPI_AUD23);

  always_comb
  begin
    card_in_o = '0;
    aud01_in_o = '0;
    aud23_in_o = '0;
    spi_in_o = '0;
    uart_in_o = '0;
    panel_in_o = '0;
    general_io_line_in_o = '0;
    ser_pad_o = '0;
    ser_oe = '0;
    par_pad_o = '0;
    par_oe = '0;
    ext_mem_addr_pin_o = '0;
    ext_mem_addr_pin_oe_n_o = '1;

    // serial groups; reserved mode 3 leaves pins undriven
    for (int g = 0; g < 2; g++)
    begin
      for (int k = 0; k < SER_PINS; k++)
      begin
        unique case (ser_mode[g])
          EPM_SER_CARD:
          begin
            ser_pad_o[g*SER_PINS+k] = card_out_i[g*SER_PINS+k];
            ser_oe[g*SER_PINS+k] = card_oe_i[g*SER_PINS+k];
            card_in_o[g*SER_PINS+k] = ser_pad_i[g*SER_PINS+k];
          end
          EPM_SER_AUDIO:
          begin
            if (k < 4)
            begin
              ser_pad_o[g*SER_PINS+k] = aud01_out_i[g*4+k];
              ser_oe[g*SER_PINS+k] = aud01_oe_i[g*4+k];
              aud01_in_o[g*4+k] = ser_pad_i[g*SER_PINS+k];
            end
            else
            begin
              ser_pad_o[g*SER_PINS+k] = general_io_line_out_i[g*SER_PINS+k];
              ser_oe[g*SER_PINS+k] = general_io_line_oe_i[g*SER_PINS+k];
              general_io_line_in_o[g*SER_PINS+k] = ser_pad_i[g*SER_PINS+k];
            end
          end
          EPM_SER_GPIO:
          begin
            ser_pad_o[g*SER_PINS+k] = general_io_line_out_i[g*SER_PINS+k];
            ser_oe[g*SER_PINS+k] = general_io_line_oe_i[g*SER_PINS+k];
            general_io_line_in_o[g*SER_PINS+k] = ser_pad_i[g*SER_PINS+k];
          end
          EPM_SER_RSVD:
          begin
            ser_oe[g*SER_PINS+k] = 1'b0;
          end
        endcase
      end
    end

    // parallel group; reserved code seven releases every pin
    if (par_mode != EPM_PAR_RSVD)
    begin
      // pixel clock, data 0-7 and control pins
      if (lo_alt)
      begin
        par_pad_o[0] = spi_out_i[0];
        par_oe[0] = spi_oe_i[0];
        spi_in_o[0] = par_pad_i[0];
        for (int k = 0; k < 2; k++)
        begin
          par_pad_o[1+k] = spi_out_i[1+k];
          par_oe[1+k] = spi_oe_i[1+k];
          spi_in_o[1+k] = par_pad_i[1+k];
        end
        for (int k = 2; k < 8; k++)
        begin
          par_pad_o[1+k] = general_io_line_out_i[10+k];
          par_oe[1+k] = general_io_line_oe_i[10+k];
          general_io_line_in_o[10+k] = par_pad_i[1+k];
        end
        for (int k = 0; k < 4; k++)
        begin
          par_pad_o[17+k] = spi_out_i[3+k];
          par_oe[17+k] = spi_oe_i[3+k];
          spi_in_o[3+k] = par_pad_i[17+k];
        end
      end
      else
      begin
        for (int k = 0; k < PAR_PINS; k++)
        begin
          if (k < 9 || k > 16 || par_mode == EPM_PAR_PANEL16)
          begin
            par_pad_o[k] = panel_out_i[k];
            par_oe[k] = panel_oe_i[k];
            panel_in_o[k] = par_pad_i[k];
          end
        end
      end

      // data 8-11 and 12-15
      for (int k = 0; k < 4; k++)
      begin
        unique case (par_mode)
          EPM_PAR_GPIO_SPI_UART_AUD2, EPM_PAR_PANEL8_AUD2_UART, EPM_PAR_GPIO_SPI_AUD23:
          begin
            par_pad_o[9+k] = aud23_out_i[k];
            par_oe[9+k] = aud23_oe_i[k];
            aud23_in_o[k] = par_pad_i[9+k];
          end
          EPM_PAR_PANEL8_SPI_AUD3, EPM_PAR_PANEL8_UART_SPI:
          begin
            par_pad_o[9+k] = spi_out_i[HI_SPI[k]];
            par_oe[9+k] = spi_oe_i[HI_SPI[k]];
            spi_in_o[HI_SPI[k]] = par_pad_i[9+k];
          end
          EPM_PAR_PANEL8_GPIO:
          begin
            par_pad_o[9+k] = general_io_line_out_i[HI_GPIO[k]];
            par_oe[9+k] = general_io_line_oe_i[HI_GPIO[k]];
            general_io_line_in_o[HI_GPIO[k]] = par_pad_i[9+k];
          end
          default:
          begin
          end
        endcase
        unique case (par_mode)
          EPM_PAR_GPIO_SPI_UART_AUD2, EPM_PAR_PANEL8_AUD2_UART, EPM_PAR_PANEL8_UART_SPI:
          begin
            par_pad_o[13+k] = uart_out_i[k];
            par_oe[13+k] = uart_oe_i[k];
            uart_in_o[k] = par_pad_i[13+k];
          end
          EPM_PAR_PANEL8_SPI_AUD3, EPM_PAR_GPIO_SPI_AUD23:
          begin
            par_pad_o[13+k] = aud23_out_i[4+k];
            par_oe[13+k] = aud23_oe_i[4+k];
            aud23_in_o[4+k] = par_pad_i[13+k];
          end
          EPM_PAR_PANEL8_GPIO:
          begin
            par_pad_o[13+k] = general_io_line_out_i[HI_GPIO[4+k]];
            par_oe[13+k] = general_io_line_oe_i[HI_GPIO[4+k]];
            general_io_line_in_o[HI_GPIO[4+k]] = par_pad_i[13+k];
          end
          default:
          begin
          end
        endcase
      end
    end

    // upper address pins: memory controller always drives in address duty
    for (int k = 0; k < 6; k++)
    begin
      if (upper_addr_select[k])
      begin
        ext_mem_addr_pin_o[k] = general_io_line_out_i[21+k];
        ext_mem_addr_pin_oe_n_o[k] = ~general_io_line_oe_i[21+k];
        general_io_line_in_o[21+k] = ext_mem_addr_pin_i[k];
      end
      else
      begin
        ext_mem_addr_pin_o[k] = ext_mem_addr_i[k];
        ext_mem_addr_pin_oe_n_o[k] = 1'b0;
      end
    end
  end

  assign ser_pad_oe_n_o = ~ser_oe;
  assign par_pad_oe_n_o = ~par_oe;
endmodule

// ===== logic/epm_pkg.sv
/*
  Types shared by the pin multiplexer files.
  Assumes epm_map.svh is on the include path.
*/
package epm_pkg;
  typedef logic [15:0] epm_word_t;

  typedef enum logic [1:0]
  {
    EPM_SER_CARD = 2'h0,
    EPM_SER_AUDIO = 2'h1,
    EPM_SER_GPIO = 2'h2,
    EPM_SER_RSVD = 2'h3
  } epm_ser_mode_t;

  typedef enum logic [2:0]
  {
    EPM_PAR_PANEL16 = 3'h0,
    EPM_PAR_GPIO_SPI_UART_AUD2 = 3'h1,
    EPM_PAR_PANEL8_GPIO = 3'h2,
    EPM_PAR_PANEL8_SPI_AUD3 = 3'h3,
    EPM_PAR_PANEL8_AUD2_UART = 3'h4,
    EPM_PAR_PANEL8_UART_SPI = 3'h5,
    EPM_PAR_GPIO_SPI_AUD23 = 3'h6,
    EPM_PAR_RSVD = 3'h7
  } epm_par_mode_t;
endpackage

// ===== logic/epm_route_reg.sv
/*
  Route select register on the CPU I/O port, with registered read data.
  Assumes single-cycle read and write strobes synchronous to clk_i.
*/
`timescale 1ns/10ps
`include "epm_map.svh"

module epm_route_reg
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // cpu port
  input wire epm_pkg::epm_word_t addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire epm_pkg::epm_word_t wdata_i,
  output epm_pkg::epm_word_t rdata_o,
  // current routing
  output epm_pkg::epm_word_t route_o
);
  import epm_pkg::*;

  epm_word_t route_r;
  epm_word_t route_nxt;
  epm_word_t rdata_r;
  epm_word_t rdata_nxt;
  logic hit;

  always_comb
  begin
    hit = (addr_i == `EPM_ROUTE_ADDR);
    route_nxt = route_r;
    rdata_nxt = rdata_r;
    if (wr_i && hit)
    begin
      route_nxt = wdata_i & `EPM_ROUTE_WMASK;
    end
    if (rd_i)
    begin
      // unmapped addresses read as zero
      rdata_nxt = hit ? route_r : '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      route_r <= `EPM_ROUTE_RESET;
      rdata_r <= '0;
    end
    else
    begin
      route_r <= route_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign route_o = route_r;
  assign rdata_o = rdata_r;
endmodule
